// [src/wload_unit.sv]
// Word load unit: partial, zero-extending and indexed FP word loads.
`timescale 1ns/1ps
//
// Contract
// [RULE1] Right part load fills low destination bytes; upper word bytes kept.
// [RULE2] Right part load of all four bytes sign-extends into bits 63..32.
// [RULE3] Otherwise upper half is kept or copies current bit 31.
// [RULE4] Left plus right loads, either order, give sign-extended word.
// [RULE5] Loaded bytes chosen by address bits 1..0 and byte order.
// [RULE6] Back-to-back partial loads to one register merge without a gap.
// [RULE7] Zero-extended load writes word into low half, clears upper half.
// [RULE8] Zero-extended load raises address error if bits 1..0 nonzero.
// [RULE9] Zero-extended load reports each exception under its own cause.
// [RULE10] Indexed FP load address is base plus index, no displacement.
// [RULE11] Indexed FP load writes the word into the FP register low word.
// [RULE12] Indexed FP load raises address error when misaligned.
// [RULE13] Indexed FP load decoded by major 010011 and function 000000.
// [RULE14] Left part load places most significant bytes in upper word part.
// [RULE15] Byte-lane selection is a fixed table over offsets and byte orders.
module wload_unit
  import wload_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wload_pkg::issue_t      issue,
  output logic                   issue_ready,
  output logic [63:0]            mem_addr,
  output logic                   mem_req,
  input  wload_pkg::mem_rsp_t    mem_rsp,
  output wload_pkg::wb_t         wb,
  output logic                   exc_valid,
  output wload_pkg::exc_cause_t  exc_cause
);
  import wload_pkg::*;

  typedef enum logic [1:0] {st_idle, st_wait, st_lane} phase_t;

  typedef struct packed {
    phase_t      phase;
    load_kind_t  kind;
    logic [63:0] addr;
    logic [63:0] rt_val;
    logic [4:0]  dest;
    logic        big_endian;
    logic [63:0] mem_data;
    logic        req;
    wb_t         wb;
    logic        exc_valid;
    exc_cause_t  exc_cause;
    logic        fwd_valid;
    logic [4:0]  fwd_dest;
    logic [63:0] fwd_data;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [3:0] keep_mask;
  logic [2:0] nbytes;

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  function automatic load_kind_t decode(input logic [31:0] ins);
    load_kind_t k;
    k = kind_none;
    if (ins[op_hi:op_lo] == fp_extended_major_opcode &&
        ins[fn_hi:fn_lo] == fn_indexed_fp_word_load) // RULE13
      k = kind_fp_indexed;
    else if (ins[op_hi:op_lo] == op_load_word_left_part)
      k = kind_left;
    else if (ins[op_hi:op_lo] == op_load_word_right_part)
      k = kind_right;
    else if (ins[op_hi:op_lo] == op_load_word_zero_ext)
      k = kind_zero_ext;
    return k;
  endfunction

  function automatic logic [63:0] sext16(input logic [15:0] v);
    return {{48{v[15]}}, v};
  endfunction

  // The word within the doubleword picked by address bit 2 and byte order.
  function automatic logic [31:0] pick_word(input logic [63:0] d,
                                            input logic [63:0] a,
                                            input logic        be);
    return (a[2] ^ be) ? d[63:32] : d[31:0];
  endfunction

  // ---------------------------------------------------------------------
  // Lane table
  // ---------------------------------------------------------------------
  wload_lane_rom u_lane (
    .mclk         (mclk),
    .rst          (rst),
    .left         (st_ff.kind == kind_left),
    .big_endian   (st_ff.big_endian),
    .offset       (st_ff.addr[1:0]), // RULE5
    .keep_mask_ff (keep_mask),
    .nbytes_ff    (nbytes)
  );

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  load_kind_t  k_in;
  logic [63:0] ea_in;
  logic [31:0] memw;
  logic [31:0] shifted;
  logic [31:0] merged;
  logic [63:0] rt_eff;
  logic [1:0]  eo;

  always_comb begin
    k_in    = decode(issue.instr);
    ea_in   = 64'h0;
    memw    = pick_word(st_ff.mem_data, st_ff.addr, st_ff.big_endian);
    eo      = st_ff.big_endian ? ~st_ff.addr[1:0] : st_ff.addr[1:0];
    shifted = 32'h0;
    merged  = 32'h0;
    rt_eff  = st_ff.rt_val;
    nxt_st  = st_ff;
    nxt_st.wb.valid  = 1'b0;
    nxt_st.exc_valid = 1'b0;
    nxt_st.req       = 1'b0;
    if (k_in == kind_fp_indexed)
      ea_in = issue.base_val + issue.index_val; // RULE10
    else
      ea_in = issue.base_val + sext16(issue.instr[15:0]);
    unique case (st_ff.phase)
      st_idle: begin
        if (issue.valid && k_in != kind_none) begin
          nxt_st.kind       = k_in;
          nxt_st.addr       = ea_in;
          nxt_st.rt_val     = issue.rt_val;
          nxt_st.big_endian = issue.big_endian;
          nxt_st.dest = (k_in == kind_fp_indexed) ?
                        issue.instr[fd_hi:fd_lo] : issue.instr[rt_hi:rt_lo];
          if ((k_in == kind_zero_ext || k_in == kind_fp_indexed) &&
              ea_in[1:0] != 2'h0) begin // RULE8 RULE12
            nxt_st.exc_valid = 1'b1;
            nxt_st.exc_cause = exc_address_error;
          end else begin
            nxt_st.req   = 1'b1;
            nxt_st.phase = st_wait;
          end
        end else if (issue.valid) begin
          nxt_st.exc_valid = 1'b1;
          nxt_st.exc_cause = exc_reserved_instr;
        end
      end
      st_wait: begin
        if (mem_rsp.valid) begin
          nxt_st.mem_data = mem_rsp.data;
          if (mem_rsp.tlb_refill || mem_rsp.tlb_invalid ||
              mem_rsp.bus_error || mem_rsp.watch) begin // RULE9
            nxt_st.exc_valid = 1'b1;
            nxt_st.exc_cause = mem_rsp.tlb_refill  ? exc_tlb_refill  :
                               mem_rsp.tlb_invalid ? exc_tlb_invalid :
                               mem_rsp.bus_error   ? exc_bus_error   :
                                                     exc_watch;
            nxt_st.phase = st_idle;
          end else begin
            nxt_st.phase = st_lane;
          end
        end
      end
      st_lane: begin
        // Forward the previous GPR load result so a following partial load merges.
        if (st_ff.fwd_valid && st_ff.fwd_dest == st_ff.dest &&
            (st_ff.kind == kind_left || st_ff.kind == kind_right))
          rt_eff = st_ff.fwd_data; // RULE6
        if (st_ff.kind == kind_right)
          shifted = memw >> {eo, 3'h0}; // RULE1
        else
          shifted = memw << {~eo, 3'h0}; // RULE14
        for (int i = 0; i < 4; i++)
          merged[i*8 +: 8] = keep_mask[i] ? rt_eff[i*8 +: 8]
                                          : shifted[i*8 +: 8];
        nxt_st.wb.valid  = 1'b1;
        nxt_st.wb.dest   = st_ff.dest;
        nxt_st.wb.to_fpr = (st_ff.kind == kind_fp_indexed);
        unique case (st_ff.kind)
          kind_left:
            // Left part always holds bit 31, so it always sign-extends.
            nxt_st.wb.data = {{32{merged[31]}}, merged}; // RULE4
          kind_right:
            if (nbytes == 3'h4)
              nxt_st.wb.data = {{32{merged[31]}}, merged}; // RULE2 RULE4
            else if (upper_keep)
              nxt_st.wb.data = {rt_eff[63:32], merged}; // RULE3
            else
              nxt_st.wb.data = {{32{merged[31]}}, merged}; // RULE3
          kind_zero_ext:
            nxt_st.wb.data = {32'h0, memw}; // RULE7
          kind_fp_indexed:
            nxt_st.wb.data = {{32{memw[31]}}, memw}; // RULE11
          default:
            nxt_st.wb.data = 64'h0;
        endcase
        nxt_st.wb.valid = (st_ff.kind != kind_none);
        nxt_st.fwd_valid = !nxt_st.wb.to_fpr;
        nxt_st.fwd_dest  = st_ff.dest;
        nxt_st.fwd_data  = nxt_st.wb.data;
        nxt_st.phase     = st_idle;
      end
      default: nxt_st.phase = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign issue_ready = (st_ff.phase == st_idle);
  assign mem_req     = st_ff.req;
  assign mem_addr    = st_ff.addr;
  assign wb          = st_ff.wb;
  assign exc_valid   = st_ff.exc_valid;
  assign exc_cause   = st_ff.exc_cause;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  zext_upper_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    (st_ff.phase == st_lane && st_ff.kind == kind_zero_ext) |=>
      wb.valid && wb.data[63:32] == 32'h0)
    else $error("zero-extended load left upper half set");

  zext_align_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
    (issue_ready && issue.valid && decode(issue.instr) == kind_zero_ext &&
     ea_in[1:0] != 2'h0) |=> exc_valid &&
      exc_cause == exc_address_error && !mem_req)
    else $error("misaligned zero-extended load not trapped");

  fp_align_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    (issue_ready && issue.valid && decode(issue.instr) == kind_fp_indexed &&
     ea_in[1:0] != 2'h0) |=> exc_valid &&
      exc_cause == exc_address_error)
    else $error("misaligned indexed fp load not trapped");

  fp_addr_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
    (issue_ready && issue.valid && decode(issue.instr) == kind_fp_indexed &&
     ea_in[1:0] == 2'h0) |=> mem_req &&
      mem_addr == $past(issue.base_val) + $past(issue.index_val))
    else $error("indexed fp address not base plus index");

  fp_dest_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (st_ff.phase == st_lane && st_ff.kind == kind_fp_indexed) |=>
      wb.valid && wb.to_fpr)
    else $error("indexed fp load not written to fp register");

  right_sign_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    (wb.valid && !wb.to_fpr && wb.data[63:32] != 32'h0) |->
      wb.data[63:32] == {32{wb.data[31]}} ||
      $past(st_ff.kind) == kind_zero_ext)
    else $error("upper half not a copy of bit 31");

  bus_cause_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    (st_ff.phase == st_wait && mem_rsp.valid && mem_rsp.bus_error &&
     !mem_rsp.tlb_refill && !mem_rsp.tlb_invalid) |=>
      exc_valid && exc_cause == exc_bus_error && !wb.valid)
    else $error("bus error not reported under its cause");

  load_latency_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
    (st_ff.phase == st_wait && mem_rsp.valid && !mem_rsp.tlb_refill &&
     !mem_rsp.tlb_invalid && !mem_rsp.bus_error && !mem_rsp.watch) |=>
      ##1 wb.valid)
    else $error("load writeback not two cycles after response");

  right_full_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    (st_ff.phase == st_lane && st_ff.kind == kind_right &&
     nbytes == 3'h4) |=> wb.data[63:32] == {32{wb.data[31]}})
    else $error("full right part load not sign-extended");

  // Either fill is legal for a short right part, so accept both.
  right_part_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    (st_ff.phase == st_lane && st_ff.kind == kind_right &&
     nbytes != 3'h4) |=> wb.data[63:32] == {32{wb.data[31]}} ||
      wb.data[63:32] == $past(rt_eff[63:32]))
    else $error("short right part load upper half invalid");

  right_keep_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    (st_ff.phase == st_lane && st_ff.kind == kind_right &&
     keep_mask[3]) |=> wb.data[31:24] == $past(rt_eff[31:24]))
    else $error("right part load overwrote a kept byte");

  left_keep_a: assert property (@(posedge mclk) disable iff (rst) // RULE14
    (st_ff.phase == st_lane && st_ff.kind == kind_left &&
     keep_mask[0]) |=> wb.data[7:0] == $past(rt_eff[7:0]))
    else $error("left part load overwrote a kept byte");

  left_sign_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    (st_ff.phase == st_lane && st_ff.kind == kind_left) |=>
      wb.data[63:32] == {32{wb.data[31]}})
    else $error("left part load not sign-extended");

  zext_word_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    (st_ff.phase == st_lane && st_ff.kind == kind_zero_ext) |=>
      wb.data[31:0] == $past(memw))
    else $error("zero-extended load word not written");

  fp_word_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (st_ff.phase == st_lane && st_ff.kind == kind_fp_indexed) |=>
      wb.data[31:0] == $past(memw))
    else $error("indexed fp load word not written");

  refill_cause_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    (st_ff.phase == st_wait && mem_rsp.valid && mem_rsp.tlb_refill) |=>
      exc_valid && exc_cause == exc_tlb_refill && !wb.valid)
    else $error("tlb refill not reported under its cause");

  reserved_op_a: assert property (@(posedge mclk) disable iff (rst) // RULE13
    (issue_ready && issue.valid &&
     issue.instr[op_hi:op_lo] == fp_extended_major_opcode &&
     issue.instr[fn_hi:fn_lo] != fn_indexed_fp_word_load) |=>
      exc_valid && exc_cause == exc_reserved_instr)
    else $error("unknown function code not reserved");
endmodule

// [src/wload_pkg.sv]
// Shared types and constants for the word load unit.
package wload_pkg;
  localparam logic [5:0] fp_extended_major_opcode = 6'h13;
  localparam logic [5:0] fn_indexed_fp_word_load  = 6'h00;
  localparam logic [5:0] op_load_word_left_part   = 6'h22;
  localparam logic [5:0] op_load_word_right_part  = 6'h26;
  localparam logic [5:0] op_load_word_zero_ext    = 6'h27;
  localparam int         op_hi = 31;
  localparam int         op_lo = 26;
  localparam int         base_hi = 25;
  localparam int         base_lo = 21;
  localparam int         rt_hi = 20;
  localparam int         rt_lo = 16;
  localparam int         fd_hi = 10;
  localparam int         fd_lo = 6;
  localparam int         fn_hi = 5;
  localparam int         fn_lo = 0;
  localparam logic [4:0] gpr_count_m1 = 5'h1F;
  localparam logic       upper_keep = 1'b0;

  typedef enum logic [2:0] {
    exc_none,
    exc_tlb_refill,
    exc_tlb_invalid,
    exc_bus_error,
    exc_address_error,
    exc_reserved_instr,
    exc_watch
  } exc_cause_t;

  typedef enum logic [2:0] {
    kind_none,
    kind_left,
    kind_right,
    kind_zero_ext,
    kind_fp_indexed
  } load_kind_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] base_val;
    logic [63:0] index_val;
    logic [63:0] rt_val;
    logic        big_endian;
  } issue_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic        tlb_refill;
    logic        tlb_invalid;
    logic        bus_error;
    logic        watch;
  } mem_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        to_fpr;
    logic [4:0]  dest;
    logic [63:0] data;
  } wb_t;
endpackage

// [src/wload_lane_rom.sv]
// Byte-lane table for the partial word loads.
`timescale 1ns/1ps
module wload_lane_rom
  import wload_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        left,
  input  wire logic        big_endian,
  input  wire logic [1:0]  offset,
  output logic       [3:0] keep_mask_ff,
  output logic       [2:0] nbytes_ff
);
  import wload_pkg::*;

  logic [1:0] eff;

  // Little and big endian mirror each other, so one table covers both.
  always_comb begin
    eff = big_endian ? ~offset : offset;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      keep_mask_ff <= 4'h0;
      nbytes_ff    <= 3'h0;
    end else begin
      unique case ({left, eff}) // RULE15
        3'h0: begin keep_mask_ff <= 4'h0; nbytes_ff <= 3'h4; end
        3'h1: begin keep_mask_ff <= 4'h8; nbytes_ff <= 3'h3; end
        3'h2: begin keep_mask_ff <= 4'hC; nbytes_ff <= 3'h2; end
        3'h3: begin keep_mask_ff <= 4'hE; nbytes_ff <= 3'h1; end
        3'h4: begin keep_mask_ff <= 4'h7; nbytes_ff <= 3'h1; end
        3'h5: begin keep_mask_ff <= 4'h3; nbytes_ff <= 3'h2; end
        3'h6: begin keep_mask_ff <= 4'h1; nbytes_ff <= 3'h3; end
        3'h7: begin keep_mask_ff <= 4'h0; nbytes_ff <= 3'h4; end
      endcase
    end
  end

  // Every offset moves one to four bytes and keeps the rest of the word.
  lane_count_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
    1'b1 |=> $countones(keep_mask_ff) + int'(nbytes_ff) == 4)
    else $error("lane table byte count does not fill the word");
endmodule

// [bench/wload_mem_model.sv]
// Memory-side model that answers each load request after a set delay.
`timescale 1ns/1ps
module wload_mem_model (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            mem_req,
  input  wire logic [3:0]      lat,
  input  wire logic [3:0]      fault,
  input  wire logic [63:0]     rd_data,
  output wload_pkg::mem_rsp_t  mem_rsp
);
  import wload_pkg::*;
  logic        busy_ff;
  logic [3:0]  wait_ff;
  logic [63:0] last_ff;

  // Idle data is the inverse of the last answer, so stale bytes never match.
  always @(posedge mclk) begin
    mem_rsp <= '{1'b0, ~last_ff, 1'b0, 1'b0, 1'b0, 1'b0};
    if (rst) begin
      busy_ff <= 1'b0;
      wait_ff <= 4'h0;
      last_ff <= 64'h0;
    end else if (busy_ff && wait_ff == 4'h0) begin
      busy_ff <= 1'b0;
      last_ff <= rd_data;
      mem_rsp <= '{1'b1, rd_data, fault[3], fault[2], fault[1], fault[0]};
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (mem_req) begin
      busy_ff <= 1'b1;
      wait_ff <= lat;
    end
  end
endmodule

// [bench/unaligned_word_load_unit_tb.sv]
// Self-checking bench for the word load unit against a behavioural model.
`timescale 1ns/1ps
module unaligned_word_load_unit_tb;
  import wload_pkg::*;
  logic        mclk;
  logic        rst;
  logic        issue_ready;
  logic        mem_req;
  logic        exc_valid;
  logic [63:0] mem_addr;
  logic [63:0] rd_data;
  logic [63:0] dw;
  logic [63:0] dw_addr;
  logic [63:0] last_wb;
  logic [3:0]  lat;
  logic [3:0]  fault;
  logic [31:0] seed;
  logic [63:0] gpr [32];
  issue_t      issue;
  mem_rsp_t    mem_rsp;
  wb_t         wb;
  exc_cause_t  exc_cause;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  wload_unit i_dut (.mclk(mclk), .rst(rst), .issue(issue),
    .issue_ready(issue_ready), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .wb(wb), .exc_valid(exc_valid),
    .exc_cause(exc_cause));
  wload_mem_model i_mem (.mclk(mclk), .rst(rst), .mem_req(mem_req),
    .lat(lat), .fault(fault), .rd_data(rd_data), .mem_rsp(mem_rsp));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ----------------------------------------------------------------
  // Reference model and checking
  // ----------------------------------------------------------------
  // The upper half copies bit 31 except for the zero-extended load.
  function automatic logic [63:0] ref_val(int k, logic [63:0] ea,
                                          logic [63:0] d, logic [31:0] rt,
                                          logic be);
    logic [31:0] w;
    logic [31:0] t;
    int          b;
    w = d[32*(ea[2] ^ be) +: 32];
    b = ea[1:0] ^ {be, be};
    if (k == 1) t = (w << 8*(3-b)) | (rt & ~(32'hFFFFFFFF << 8*(3-b)));
    else if (k == 2) t = (w >> 8*b) | (rt & ~(32'hFFFFFFFF >> 8*b));
    else t = w;
    return (k == 3) ? {32'h0, w} : {{32{t[31]}}, t};
  endfunction

  task automatic chk(input logic [74:0] got, input logic [74:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Kind 0 unknown, 1 left part, 2 right part, 3 zero-extended, 4 indexed.
  task automatic ld(input int k, input int o, input int dst, input int be,
                    input int nd, input int stale, input int flt,
                    input int fn);
    logic [63:0] ea;
    logic [63:0] ix;
    logic [63:0] base;
    logic [15:0] off;
    logic [31:0] ins;
    logic [74:0] got;
    logic [74:0] exp;
    logic        res;
    exc_cause_t  c;
    int          n;
    if (nd != 0) begin
      dw_addr = {rnd(), rnd()};
      dw = {rnd(), rnd()};
    end
    ea = {dw_addr[63:3], 3'(o)};
    off = 16'(rnd());
    ix = {rnd(), rnd()};
    base = (k == 4) ? ea - ix : ea - {{48{off[15]}}, off};
    case (k)
      0: ins = {6'h3B, 26'h0};
      1: ins = {op_load_word_left_part, 5'h1, 5'(dst), off};
      2: ins = {op_load_word_right_part, 5'h1, 5'(dst), off};
      3: ins = {op_load_word_zero_ext, 5'h1, 5'(dst), off};
      default: ins = {fp_extended_major_opcode, 15'h880, 5'(dst), 6'(fn)};
    endcase
    c = flt[3] ? exc_tlb_refill : flt[2] ? exc_tlb_invalid
      : flt[1] ? exc_bus_error : exc_watch;
    res = k == 0 || (k == 4 && 6'(fn) != fn_indexed_fp_word_load);
    if (res) exp = {1'b1, exc_reserved_instr, 71'h0};
    else if (k > 2 && ea[1:0] != 2'h0) exp = {1'b1, exc_address_error, 71'h0};
    else if (flt != 0) exp = {1'b1, c, 71'h0};
    else exp = {4'h0, 1'b1, 1'(k == 4), 5'(dst),
                ref_val(k, ea, dw, gpr[dst][31:0], 1'(be))};
    @(posedge mclk);
    lat <= 4'(rnd() % 6);
    fault <= 4'(flt);
    rd_data <= dw;
    issue <= '{1'b1, ins, base, ix, (stale != 0) ? ~gpr[dst] : gpr[dst],
               1'(be)};
    @(negedge mclk);
    for (n = 0; n < 50 && issue_ready !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    issue.valid <= 1'b0;
    got = '1;
    for (n = 0; n < 60 && got === '1; n++) begin
      @(negedge mclk);
      if (exc_valid === 1'b1) got = {1'b1, exc_cause, 71'h0};
      else if (wb.valid === 1'b1)
        got = {4'h0, 1'b1, wb.to_fpr, wb.dest, wb.data};
    end
    chk(got, exp);
    if (!res && (k < 3 || ea[1:0] == 2'h0))
      chk(75'(mem_addr), 75'(ea));
    if (exp[74] == 1'b0) begin
      last_wb = got[63:0];
      if (k < 4) gpr[dst] = exp[63:0];
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    seed = 32'hF014199D;
    rst = 1'b1;
    issue = '0;
    lat = 4'h0;
    fault = 4'h0;
    rd_data = 64'h0;
    foreach (gpr[i]) gpr[i] = {rnd(), rnd()};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int be = 0; be < 2; be++) begin
      for (int o = 0; o < 4; o++) begin
        ld(1, o, 3, be, 1, 0, 0, 0);
        ld(2, o, 4, be, 0, 0, 0, 0);
        ld(3, o + 4, 6, be, 1, 0, 0, 0);
        ld(4, o, 16 + o, be, 1, 0, 0, 0);
      end
    end
    $display("test lane table done");
    for (int i = 0; i < 4; i++) begin
      ld(i[0] ? 2 : 1, (i[0] ^ i[1]) ? 1 : 4, 5, i[1], 1, 0, 0, 0);
      ld(i[0] ? 1 : 2, (i[0] ^ i[1]) ? 4 : 1, 5, i[1], 0, 1, 0, 0);
      chk(75'(last_wb), 75'(i[1] ? {{32{dw[55]}}, dw[55:24]}
                                 : {{32{dw[39]}}, dw[39:8]}));
    end
    $display("test merge pairs done");
    for (int i = 0; i < 5; i++) begin
      ld(3, 0, 7, 0, 1, 0, (i == 4) ? 15 : 8 >> i, 0);
    end
    ld(0, 0, 7, 0, 1, 0, 0, 0);
    ld(4, 0, 17, 1, 1, 0, 0, 1);
    $display("test faults done");
    for (int i = 0; i < 60; i++) begin
      k = 1 + rnd() % 4;
      ld(k, rnd() % 8, (k == 4) ? 16 + rnd() % 16 : 1 + rnd() % 7,
         rnd() % 2, rnd() % 2, 0, (rnd() % 8 == 0) ? rnd() % 16 : 0, 0);
    end
    $display("test random mix done");
    close_out();
  end
endmodule
